// ==== hdl/plmi_host_port.sv ====
// I2C target command port of the powerline modem
// Notes on behaviour
// [R1] Receive queue overflow sets error bit 1.
// [R2] Writing payload into a full transmit queue sets error bit 2.
// [R3] An unknown command byte sets error bit 3.
// [R4] Error fetch: write 0x44, 0x11, restart, read 0x45, one byte, stop.
// [R5] Completing the error fetch drops the interrupt raised by the fault flag.
// [R6] The port answers only when both select pins read 11.
// [R7] Carrier register starts at 13 MHz after reset.
// [R8] START is data falling while clock is high.
// [R9] Address, command and written bytes are acknowledged in slot nine.
// [R10] Register read: 0x44, 0xfd, register address, restart 0x45, byte, NACK, stop.
// [R11] Register write: 0x44, 0xf5, register address, data, all acknowledged, stop.
// [R12] Command 0x34 opens a slowest-codec frame; following bytes are payload.
// [R13] Close: restart, 0x44, command 0x0f, both acknowledged, then stop.
// [R14] Event fetch: 0x01, restart 0x45, eight bits, NACK, stop.
// [R15] Host ACKs drained bytes while interrupt is low, NACKs once high.
// [R16] Status reads 0x04 when only a received frame is pending.
// [R17] Status reads 0x30 after a frame was drained and queue emptied.
// [R18] Interrupt pin high signals a pending event.
// [R19] Host breaks a drain for an event fetch when interrupt rises.
// [R20] Event fetch clears interrupt; fault flag stays until error fetch.
// [R21] An empty queue during a drain yields dummy zero bytes.
// [R22] Read address for a drain is refused when interrupt is already high.
// [R23] Any error bit raises the fault flag and the interrupt.
// [R24] Error bits 0 and 7..4 always read zero.
// [R25] Error bits stay set until the error fetch returns them.
`timescale 1ns/100ps
module plmi_host_port
    import plmi_pkg::*;
#(
    parameter int REG_AW = 3
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        sclPin,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    input  wire logic [1:0]  ifSelPin,
    output logic             intPin,
    input  wire plmi_rxq_t   rxq,
    input  wire logic        rxValid,
    output logic             rxTake,
    input  wire logic        rxOverflow,
    input  wire logic        rxFrameEnd,
    output plmi_txq_t        txq,
    input  wire logic        txFull,
    output plmi_frame_t      frameCtl,
    output logic [7:0]       carrierMhz
);
    localparam int REG_N = 1 << REG_AW;

    logic [3:0]  pinS;
    logic        sclS, sdaS, selOk;
    logic        sclPrev_r, sdaPrev_r;
    logic        sclRise, sclFall, startEv, stopEv;

    plmi_state_t state_r, state_nxt;
    plmi_fetch_t fetch_r, fetch_nxt;
    logic [3:0]  bitCnt_r, bitCnt_nxt;
    logic [1:0]  byteIdx_r, byteIdx_nxt;
    logic [7:0]  shIn_r, shIn_nxt, shOut_r, shOut_nxt;
    logic [7:0]  cmd_r, cmd_nxt, regAddr_r, regAddr_nxt;
    logic [7:0]  errBits_r, errBits_nxt;
    logic        inAck_r, inAck_nxt, hostSlot_r, hostSlot_nxt;
    logic        oe_r, oe_nxt, payload_r, payload_nxt;
    logic        stFrame_r, stFrame_nxt, stEof_r, stEof_nxt;
    logic        int_r, int_nxt, take_r, take_nxt;
    plmi_txq_t   tx_r, tx_nxt;
    plmi_frame_t frame_r, frame_nxt;
    logic [7:0]  regs_r [REG_N];
    logic [7:0]  regs_nxt [REG_N];
    logic        illegalEv, txOvfEv, ackGo, drainNack, errDone, intDone;
    logic        eofEv, pop;
    logic [7:0]  b;

    plmi_sync #(.W(4)) uSync (
        .clk   (clk),
        .reset (reset),
        .d     ({ifSelPin, sclPin, sdaIn}),
        .q     (pinS)
    );

    assign selOk   = pinS[3:2] == IF_SEL_I2C;
    assign sclS    = pinS[1];
    assign sdaS    = pinS[0];
    assign sclRise = sclS && !sclPrev_r;
    assign sclFall = !sclS && sclPrev_r;
    assign startEv = sclS && sclPrev_r && sdaPrev_r && !sdaS;  // R8
    assign stopEv  = sclS && sclPrev_r && !sdaPrev_r && sdaS;

    function automatic logic [7:0] regRead(input logic [7:0] a, input logic [7:0] v);
        regRead = (a < 8'(REG_N)) ? v : 8'h00;
    endfunction : regRead

    function automatic logic [7:0] statusByte(input logic err, input logic eof,
                                              input logic empty, input logic frm);
        statusByte        = 8'h00;
        statusByte[ST_ERR]   = err;
        statusByte[ST_EOF]   = eof;
        statusByte[ST_EMPTY] = empty;
        statusByte[ST_FRAME] = frm;
    endfunction : statusByte

    always_comb begin
        state_nxt    = state_r;
        fetch_nxt    = fetch_r;
        bitCnt_nxt   = bitCnt_r;
        byteIdx_nxt  = byteIdx_r;
        shIn_nxt     = shIn_r;
        shOut_nxt    = shOut_r;
        cmd_nxt      = cmd_r;
        regAddr_nxt  = regAddr_r;
        inAck_nxt    = inAck_r;
        hostSlot_nxt = hostSlot_r;
        oe_nxt       = oe_r;
        payload_nxt  = payload_r;
        regs_nxt     = regs_r;
        tx_nxt       = '{write: 1'b0, data: tx_r.data};
        frame_nxt    = '{open: 1'b0, close: 1'b0, codec: frame_r.codec};
        illegalEv    = 1'b0;
        txOvfEv      = 1'b0;
        ackGo        = 1'b0;
        drainNack    = 1'b0;
        errDone      = 1'b0;
        intDone      = 1'b0;
        pop          = 1'b0;
        b            = shIn_r;
        if (startEv) begin
            state_nxt   = stAddr;
            bitCnt_nxt  = 4'h0;
            byteIdx_nxt = 2'h0;
            inAck_nxt   = 1'b0;
            oe_nxt      = 1'b0;
            payload_nxt = 1'b0;
        end else if (stopEv) begin
            state_nxt   = stIdle;
            fetch_nxt   = fNone;
            inAck_nxt   = 1'b0;
            oe_nxt      = 1'b0;
            payload_nxt = 1'b0;
        end else if (sclRise && state_r != stIdle) begin
            if (bitCnt_r != 4'h8) begin
                shIn_nxt   = {shIn_r[6:0], sdaS};
                bitCnt_nxt = bitCnt_r + 4'h1;
            end else begin
                bitCnt_nxt = 4'h0;
                if (hostSlot_r) begin
                    hostSlot_nxt = 1'b0;
                    errDone      = fetch_r == fErr;   // R5 R25
                    intDone      = fetch_r == fInt;   // R20
                    fetch_nxt    = fNone;
                    if (sdaS) begin
                        state_nxt = stIdle;           // R15
                    end else begin
                        pop       = rxValid;          // R21
                        shOut_nxt = rxValid ? rxq.data : 8'h00;
                    end
                end
            end
        end else if (sclFall && state_r != stIdle) begin
            if (inAck_r) begin
                inAck_nxt = 1'b0;
                oe_nxt    = state_r == stRead && !shOut_r[7];
            end else if (bitCnt_r == 4'h8) begin
                inAck_nxt = 1'b0;
                case (state_r)
                    stAddr: begin
                        if (selOk && b[7:1] == ADDR7) begin   // R6
                            if (!b[0]) begin
                                state_nxt   = stWrite;
                                byteIdx_nxt = 2'h0;
                                ackGo       = 1'b1;
                            end else if (fetch_r != fNone) begin  // R4 R10 R14
                                state_nxt = stRead;
                                ackGo     = 1'b1;
                                case (fetch_r)
                                    fInt:    shOut_nxt = statusByte(|errBits_r, stEof_r,
                                                                    !rxValid, stFrame_r);  // R16 R17
                                    fErr:    shOut_nxt = errBits_r & ~ERR_RSVD;  // R24
                                    default: shOut_nxt = regRead(regAddr_r,
                                                         regs_r[regAddr_r[REG_AW-1:0]]);
                                endcase
                            end else if (int_r) begin
                                drainNack = 1'b1;             // R22
                                state_nxt = stIdle;
                            end else begin
                                state_nxt = stRead;
                                ackGo     = 1'b1;
                                pop       = rxValid;          // R21
                                shOut_nxt = rxValid ? rxq.data : 8'h00;
                            end
                        end else begin
                            state_nxt = stIdle;
                        end
                    end
                    stWrite: begin
                        ackGo = 1'b1;                          // R9
                        if (byteIdx_r != 2'h3) begin
                            byteIdx_nxt = byteIdx_r + 2'h1;
                        end
                        if (byteIdx_r == 2'h0) begin
                            cmd_nxt = b;
                            case (b)
                                CMD_RD_INT: fetch_nxt = fInt;
                                CMD_RD_ERR: fetch_nxt = fErr;
                                CMD_RD_REG, CMD_WR_REG: fetch_nxt = fNone;
                                CMD_CLOSE:  frame_nxt.close = 1'b1;   // R13
                                default: begin
                                    if (b[3:0] == CMD_OPEN_LO && b[7:6] == 2'h0) begin
                                        frame_nxt.open  = 1'b1;       // R12
                                        frame_nxt.codec = b[5:4];
                                        payload_nxt     = 1'b1;
                                    end else begin
                                        illegalEv = 1'b1;             // R3
                                    end
                                end
                            endcase
                        end else if (payload_r) begin
                            txOvfEv = txFull;                         // R2
                            tx_nxt  = '{write: !txFull, data: b};
                        end else if (byteIdx_r == 2'h1 && cmd_r == CMD_RD_REG) begin
                            regAddr_nxt = b;                          // R10
                            fetch_nxt   = fReg;
                        end else if (byteIdx_r == 2'h1 && cmd_r == CMD_WR_REG) begin
                            regAddr_nxt = b;                          // R11
                        end else if (byteIdx_r == 2'h2 && cmd_r == CMD_WR_REG &&
                                     regAddr_r < 8'(REG_N)) begin
                            regs_nxt[regAddr_r[REG_AW-1:0]] = b;      // R11
                        end
                    end
                    default: begin
                        inAck_nxt    = 1'b1;
                        hostSlot_nxt = 1'b1;
                    end
                endcase
                if (state_r != stRead) begin
                    inAck_nxt = ackGo;
                    oe_nxt    = ackGo;
                end else begin
                    oe_nxt = 1'b0;
                end
            end else if (state_r == stRead && bitCnt_r != 4'h0) begin
                shOut_nxt = {shOut_r[6:0], 1'b0};
                oe_nxt    = !shOut_r[6];
            end
        end
        eofEv       = pop && rxq.last;
        take_nxt    = pop;
        errBits_nxt = errDone ? 8'h00 : errBits_r;                    // R25
        errBits_nxt[ERR_RXOV] = errBits_nxt[ERR_RXOV] | rxOverflow;   // R1
        errBits_nxt[ERR_TXOV] = errBits_nxt[ERR_TXOV] | txOvfEv;      // R2
        errBits_nxt[ERR_ILL]  = errBits_nxt[ERR_ILL] | illegalEv;     // R3
        stFrame_nxt = (stFrame_r && !intDone) || rxFrameEnd;          // R16
        stEof_nxt   = (stEof_r && !intDone) || eofEv;                 // R17
        int_nxt     = |errBits_nxt || stFrame_nxt || stEof_nxt;       // R18 R23
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sclPrev_r  <= 1'b1;
            sdaPrev_r  <= 1'b1;
            state_r    <= stIdle;
            fetch_r    <= fNone;
            bitCnt_r   <= 4'h0;
            byteIdx_r  <= 2'h0;
            shIn_r     <= 8'h00;
            shOut_r    <= 8'h00;
            cmd_r      <= 8'h00;
            regAddr_r  <= 8'h00;
            inAck_r    <= 1'b0;
            hostSlot_r <= 1'b0;
            oe_r       <= 1'b0;
            payload_r  <= 1'b0;
            errBits_r  <= 8'h00;
            stFrame_r  <= 1'b0;
            stEof_r    <= 1'b0;
            int_r      <= 1'b0;
            take_r     <= 1'b0;
            tx_r       <= '0;
            frame_r    <= '0;
            for (int i = 0; i < REG_N; i++) begin
                regs_r[i] <= (i == CARRIER_IDX) ? CARRIER_RST : 8'h00;   // R7
            end
        end else begin
            sclPrev_r  <= sclS;
            sdaPrev_r  <= sdaS;
            state_r    <= state_nxt;
            fetch_r    <= fetch_nxt;
            bitCnt_r   <= bitCnt_nxt;
            byteIdx_r  <= byteIdx_nxt;
            shIn_r     <= shIn_nxt;
            shOut_r    <= shOut_nxt;
            cmd_r      <= cmd_nxt;
            regAddr_r  <= regAddr_nxt;
            inAck_r    <= inAck_nxt;
            hostSlot_r <= hostSlot_nxt;
            oe_r       <= oe_nxt;
            payload_r  <= payload_nxt;
            errBits_r  <= errBits_nxt;
            stFrame_r  <= stFrame_nxt;
            stEof_r    <= stEof_nxt;
            int_r      <= int_nxt;
            take_r     <= take_nxt;
            tx_r       <= tx_nxt;
            frame_r    <= frame_nxt;
            regs_r     <= regs_nxt;
        end
    end

    // Open drain: only ever pulls low, the host's pull-up supplies the one
    assign sdaOut     = 1'b0;
    assign sdaOe      = oe_r;
    assign intPin     = int_r;
    assign rxTake     = take_r;
    assign txq        = tx_r;
    assign frameCtl   = frame_r;
    assign carrierMhz = regs_r[CARRIER_IDX];

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_ERR_RX: assert property (rxOverflow |=> errBits_r[ERR_RXOV])  // R1
        else $error("rx overflow not flagged");
    AST_ERR_TX: assert property (txOvfEv |=> errBits_r[ERR_TXOV] && !tx_r.write)  // R2
        else $error("tx overflow not flagged");
    AST_ERR_ILL: assert property (illegalEv |=> errBits_r[ERR_ILL] && oe_r)  // R3
        else $error("illegal command not flagged or not acked");
    AST_RSVD: assert property ((errBits_r & ERR_RSVD) == 8'h00)  // R24
        else $error("reserved error bit set");
    AST_INT_ERR: assert property (|errBits_r |-> int_r)  // R23
        else $error("error bit without interrupt");
    AST_ERR_CLR: assert property (errDone && !rxOverflow |=> errBits_r == 8'h00)  // R25
        else $error("error fetch did not clear bits");
    AST_INT_CLR: assert property (intDone && errBits_r == 8'h00 && !rxFrameEnd
                                  && !rxOverflow && !pop |=> !int_r)  // R20
        else $error("event fetch did not clear interrupt");
    AST_START: assert property (startEv |=> state_r == stAddr && !oe_r)  // R8
        else $error("start not recognised");
    AST_ACK: assert property (ackGo |=> oe_r && inAck_r)  // R9
        else $error("ack not driven");
    AST_DRAIN_NACK: assert property (drainNack |=> !oe_r && state_r == stIdle)  // R22
        else $error("drain address acked with interrupt high");
    AST_SEL: assert property (!selOk && sclFall && state_r == stAddr && bitCnt_r == 4'h8
                              |=> !oe_r)  // R6
        else $error("answered with wrong interface select");
    AST_DUMMY: assert property (pop |=> rxTake ##1 !rxTake)  // R21
        else $error("queue pop not a single pulse");

    COV_DRAIN: cover property (rxTake ##[1:200] rxTake);
    COV_ERR_FETCH: cover property (errDone);
    COV_OPEN: cover property (frameCtl.open ##[1:400] txq.write);
    COV_REFUSE: cover property (drainNack);
endmodule : plmi_host_port

// ==== hdl/plmi_pkg.sv ====
// Constants and types for the powerline modem I2C host port
package plmi_pkg;
    localparam logic [6:0] ADDR7       = 7'h22;  // Write byte 0x44, read byte 0x45
    localparam logic [7:0] CMD_RD_INT  = 8'h01;
    localparam logic [7:0] CMD_RD_ERR  = 8'h11;
    localparam logic [7:0] CMD_RD_REG  = 8'hfd;
    localparam logic [7:0] CMD_WR_REG  = 8'hf5;
    localparam logic [7:0] CMD_CLOSE   = 8'h0f;
    localparam logic [3:0] CMD_OPEN_LO = 4'h4;   // 0x04..0x34, codec in bits 5:4
    localparam logic [1:0] IF_SEL_I2C  = 2'h3;
    localparam logic [7:0] CARRIER_RST = 8'h0d;  // 13 MHz
    localparam int         CARRIER_IDX = 0;
    localparam int         ST_FRAME    = 2;
    localparam int         ST_EMPTY    = 4;
    localparam int         ST_EOF      = 5;
    localparam int         ST_ERR      = 7;
    localparam int         ERR_RXOV    = 1;
    localparam int         ERR_TXOV    = 2;
    localparam int         ERR_ILL     = 3;
    localparam logic [7:0] ERR_RSVD    = 8'hf1;

    typedef enum logic [1:0] {stIdle, stAddr, stWrite, stRead} plmi_state_t;
    typedef enum logic [1:0] {fNone, fInt, fErr, fReg} plmi_fetch_t;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } plmi_rxq_t;

    typedef struct packed {
        logic       write;
        logic [7:0] data;
    } plmi_txq_t;

    typedef struct packed {
        logic       open;
        logic       close;
        logic [1:0] codec;
    } plmi_frame_t;
endpackage : plmi_pkg

// ==== hdl/plmi_sync.sv ====
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module plmi_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : plmi_sync

// ==== testbench/plmi_host_model.sv ====
// Behavioural I2C bus master standing in for the host controller
`timescale 1ns/100ps
module plmi_host_model (
    output logic      sclPin,
    output logic      sdaDrv,
    input  wire logic sda,
    input  wire logic intPin
);
    initial begin
        sclPin = 1'b1;
        sdaDrv = 1'b1;
    end

    // 250 ns low, 150 ns high; sampled late so slow answers still land
    task automatic bit_slot(input logic b, output logic s);
        #100 sdaDrv = b;
        #150 sclPin = 1'b1;
        #150 s = sda;
        sclPin = 1'b0;
    endtask : bit_slot

    task automatic start_cond();
        #100 sdaDrv = 1'b1;
        #150 sclPin = 1'b1;
        #100 sdaDrv = 1'b0;
        #100 sclPin = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        #100 sdaDrv = 1'b0;
        #150 sclPin = 1'b1;
        #100 sdaDrv = 1'b1;
        #200;
    endtask : stop_cond

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(d[i], s);
        bit_slot(1'b1, s);
        ack = ~s;
    endtask : write_byte

    task automatic read_byte(input logic ackOut, input logic watchInt, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
        bit_slot(~(ackOut && !(watchInt && intPin !== 1'b0)), s);
    endtask : read_byte
endmodule : plmi_host_model

// ==== testbench/plmi_host_port_bench.sv ====
// Self-checking bench for the powerline modem I2C host port
`timescale 1ns/100ps
module plmi_host_port_bench;
    import plmi_pkg::*;
    logic        clk = 1'b0;
    logic        reset;
    logic        sclPin;
    logic        sdaDrv;
    logic        sdaOut;
    logic        sdaOe;
    logic        sdaWire;
    logic [1:0]  ifSelPin;
    logic        intPin;
    plmi_rxq_t   rxq;
    logic        rxValid;
    logic        rxTake;
    logic        rxOverflow;
    logic        rxFrameEnd;
    plmi_txq_t   txq;
    logic        txFull;
    plmi_frame_t frameCtl;
    logic [7:0]  carrierMhz;
    logic [7:0]  rxMem [4];
    int          rxHead;
    int          rxCount;
    int          txWrites;
    int          closes;
    int          opens;
    logic [7:0]  txLast;
    int          failures;
    int          compares;
    logic        ack;
    logic [7:0]  rd;

    // Open drain with pull-up; an empty queue shows junk the port must not pass on
    assign sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);
    assign rxValid = rxHead < rxCount;
    assign rxq = rxValid ? {rxHead == rxCount - 1, rxMem[rxHead[1:0]]} : 9'h1ff;

    always #25 clk = ~clk;

    always @(posedge clk) begin
        if (rxTake) rxHead <= rxHead + 1;
        if (txq.write) txWrites <= txWrites + 1;
        if (txq.write) txLast <= txq.data;
        if (frameCtl.close) closes <= closes + 1;
        if (frameCtl.open) opens <= opens + 1;
    end

    plmi_host_port #(.REG_AW(3)) plmi_host_port_i (
        .clk(clk), .reset(reset), .sclPin(sclPin), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .ifSelPin(ifSelPin), .intPin(intPin), .rxq(rxq), .rxValid(rxValid), .rxTake(rxTake),
        .rxOverflow(rxOverflow), .rxFrameEnd(rxFrameEnd), .txq(txq), .txFull(txFull),
        .frameCtl(frameCtl), .carrierMhz(carrierMhz));

    plmi_host_model plmi_host_model_i (.sclPin(sclPin), .sdaDrv(sdaDrv), .sda(sdaWire), .intPin(intPin));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : chk1

    task automatic wr(input logic [7:0] d);
        plmi_host_model_i.write_byte(d, ack);
        chk1(ack, 1'b1, "byte acknowledge");
    endtask : wr

    task automatic fetch(input logic [7:0] cmd, input logic useAddr, input logic [7:0] a, output logic [7:0] d);
        plmi_host_model_i.start_cond();
        wr(8'h44);
        wr(cmd);
        if (useAddr) wr(a);
        plmi_host_model_i.start_cond();
        wr(8'h45);
        plmi_host_model_i.read_byte(1'b0, 1'b0, d);
        plmi_host_model_i.stop_cond();
    endtask : fetch

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        plmi_host_model_i.start_cond();
        wr(8'h44);
        wr(8'hf5);
        wr(a);
        wr(d);
        plmi_host_model_i.stop_cond();
    endtask : reg_wr

    task automatic summarize();
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    initial begin
        #1_000_000;
        failures++;
        summarize();
    end

    initial begin
        reset = 1'b1;
        ifSelPin = 2'b01;
        {rxOverflow, rxFrameEnd, txFull} = 3'b000;
        {rxHead, rxCount, txWrites, closes, opens, failures, compares} = '0;
        txLast = 8'h00;
        tick(6);
        reset = 1'b0;
        tick(4);
        chk8(carrierMhz, 8'h0d, "carrier after reset");
        plmi_host_model_i.start_cond();
        plmi_host_model_i.write_byte(8'h44, ack);
        plmi_host_model_i.stop_cond();
        chk1(ack, 1'b0, "answer with other straps");
        ifSelPin = 2'b11;
        tick(4);
        reg_wr(8'h00, 8'h5a);
        tick(2);
        chk8(carrierMhz, 8'h5a, "carrier written");
        reg_wr(8'h03, 8'ha5);
        fetch(8'hfd, 1'b1, 8'h03, rd);
        chk8(rd, 8'ha5, "register read back");
        fetch(8'hfd, 1'b1, 8'h09, rd);
        chk8(rd, 8'h00, "unmapped register");
        for (int c = 0; c < 4; c++) begin
            plmi_host_model_i.start_cond();
            wr(8'h44);
            wr({c[1:0], 4'h4});
            chk8({6'h00, frameCtl.codec}, {6'h00, c[1:0]}, "codec choice");
            wr(8'h30 + c[7:0]);
            plmi_host_model_i.start_cond();
            wr(8'h44);
            wr(8'h0f);
            plmi_host_model_i.stop_cond();
        end
        tick(2);
        chk8(txWrites[7:0], 8'h04, "payload count");
        chk8(txLast, 8'h33, "last payload");
        chk8(closes[7:0], 8'h04, "close count");
        chk8(opens[7:0], 8'h04, "open count");
        // Faults of all three kinds before the event and error fetches
        txFull = 1'b1;
        plmi_host_model_i.start_cond();
        wr(8'h44);
        wr(8'h34);
        wr(8'h99);
        plmi_host_model_i.stop_cond();
        txFull = 1'b0;
        plmi_host_model_i.start_cond();
        wr(8'h44);
        wr(8'h77);
        plmi_host_model_i.stop_cond();
        rxOverflow = 1'b1;
        tick(1);
        rxOverflow = 1'b0;
        tick(4);
        chk8(txWrites[7:0], 8'h04, "payload into full queue");
        chk1(intPin, 1'b1, "interrupt on fault");
        fetch(8'h01, 1'b0, 8'h00, rd);
        chk8(rd, 8'h90, "event byte with fault");
        tick(4);
        chk1(intPin, 1'b1, "fault survives event fetch");
        fetch(8'h11, 1'b0, 8'h00, rd);
        chk8(rd, 8'h0e, "error byte");
        tick(4);
        chk1(intPin, 1'b0, "interrupt after error fetch");
        fetch(8'h11, 1'b0, 8'h00, rd);
        chk8(rd, 8'h00, "error byte cleared");
        // Two-byte frame arrives and is drained
        rxMem[0] = 8'hc3;
        rxMem[1] = 8'h3c;
        rxCount = 2;
        rxFrameEnd = 1'b1;
        tick(1);
        rxFrameEnd = 1'b0;
        tick(4);
        chk1(intPin, 1'b1, "interrupt on frame");
        plmi_host_model_i.start_cond();
        plmi_host_model_i.write_byte(8'h45, ack);
        plmi_host_model_i.stop_cond();
        chk1(ack, 1'b0, "drain while interrupt high");
        fetch(8'h01, 1'b0, 8'h00, rd);
        chk8(rd, 8'h04, "event byte for frame");
        tick(4);
        chk1(intPin, 1'b0, "interrupt after event fetch");
        plmi_host_model_i.start_cond();
        wr(8'h45);
        for (int i = 0; i < 2; i++) begin
            plmi_host_model_i.read_byte(1'b1, 1'b1, rd);
            chk8(rd, i == 0 ? 8'hc3 : 8'h3c, "drained byte");
        end
        chk1(intPin, 1'b1, "interrupt once frame drained");
        fetch(8'h01, 1'b0, 8'h00, rd);
        chk8(rd, 8'h30, "event byte after drain");
        tick(4);
        chk1(intPin, 1'b0, "interrupt after drain fetch");
        // Empty queue: dummy zeros and no pops
        plmi_host_model_i.start_cond();
        wr(8'h45);
        plmi_host_model_i.read_byte(1'b1, 1'b1, rd);
        chk8(rd, 8'h00, "first dummy byte");
        plmi_host_model_i.read_byte(1'b0, 1'b0, rd);
        chk8(rd, 8'h00, "second dummy byte");
        plmi_host_model_i.stop_cond();
        chk8(rxHead[7:0], 8'h02, "pops of the queue");
        summarize();
    end
endmodule : plmi_host_port_bench
